// ### cicc_core.sv
// Interrupt, wake-up and instruction cycle control with APB registers
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RL1) Any request flag rising wakes from sleep
// (RL2) Software presets flag to suppress its wake-up
// (RL3) Request flags stay set until serviced/cleared
// (RL4) Group service clears only the grouped flag
// (RL5) Interrupt entry pushes only the program counter
// (RL6) Interrupt return pops and sets global enable
// (RL7) Plain return pops, global enable unchanged
// (RL8) Instruction cycle is four system clocks
// (RL9) Jump, call, returns, table read: two cycles
// (RL10) Program counter low write jumps, extra cycle
// (RL11) Taken skip costs one extra cycle
// (RL12) Test instruction continues or skips next one
// (RL13) Bit set/clear modifies only selected bit
// (RL14) Logic result zero sets zero flag
// (RL15) Add carry above 255, subtract borrow
// (RL16) Increment and decrement change by one
// (RL17) Rotates by one bit, carry variants
// (RL18) Return resumes after the calling instruction
// (RL19) Table read moves program data to memory
// (RL20) Software avoids calls with one level left
// (RL21) Interrupt entry clears global enable
// (RL22) No acknowledge while the stack is full
// (RL23) Acknowledge only at whole instruction boundary
module cicc_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tb_event,
  input wire logic [1:0] member_event,
  input wire logic instr_valid,
  input wire cicc_pkg::cicc_instr_t instr,
  output logic instr_take,
  output logic [cicc_pkg::PC_W-1:0] pc,
  output logic [7:0] acc,
  output logic zero_flag,
  output logic carry_flag,
  output logic global_interrupt_enable,
  output cicc_pkg::cicc_wr_t mem_wr,
  output logic tab_rd,
  output logic [cicc_pkg::PC_W-1:0] tab_addr,
  input wire logic [15:0] tab_data,
  output logic [7:0] tblh,
  output logic sleeping
);
  import cicc_pkg::*;

  // ==========================================
  // State and helpers
  cicc_regs_t r;
  cicc_regs_t n;
  cicc_alu_t alu;
  logic [PC_W-1:0] stk_top;
  logic [STK_LW-1:0] stk_lvl;
  logic stk_full;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_d;
  logic end_cyc;
  logic bnd;
  logic extra;
  logic pend;
  logic wr_acc;
  logic hit;
  logic [3:0] ev;
  logic apb_setup;
  logic apb_write;
  logic wake;

  // ==========================================
  // Decoders shared by pending logic and source choice
  function automatic logic tb_req(input logic [3:0] f, input logic [1:0] e);
    tb_req = f[FLG_TB] && e[0];
  endfunction

  function automatic logic grp_req(input logic [3:0] f, input logic [1:0] e);
    grp_req = f[FLG_GRP] && e[1];
  endfunction

  // Register map decode for the error response
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFS_CTRL) || (a == OFS_FLAG) ||
      (a == OFS_STAT) || (a == OFS_DATA);
  endfunction

  cicc_alu u_alu (
    .ir(r.ir),
    .acc(r.acc),
    .c_in(r.c),
    .res(alu)
  );

  cicc_stack u_stack (
    .clk(clk),
    .rst(rst),
    .push(push),
    .pop(pop),
    .push_data(push_d),
    .top(stk_top),
    .level(stk_lvl),
    .full(stk_full)
  );

  // ==========================================
  // Outputs, all from registers
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign instr_take = r.take;
  assign pc = r.pc;
  assign acc = r.acc;
  assign zero_flag = r.z;
  assign carry_flag = r.c;
  assign global_interrupt_enable = r.gie;
  assign mem_wr = r.wr;
  assign tab_rd = r.tab_rd;
  assign tab_addr = r.tab_addr;
  assign tblh = r.tblh;
  assign sleeping = r.sleeping;

  always_comb begin
    n = r;
    push = 1'b0;
    pop = 1'b0;
    push_d = r.pc;
    bnd = 1'b0;
    extra = 1'b0;
    wr_acc = 1'b0;
    n.wr.en = 1'b0;
    n.take = 1'b0;
    n.tab_rd = 1'b0;
    // Group flag follows any member event; member flags kept apart
    ev[FLG_TB] = tb_event;
    ev[FLG_GRP] = |member_event;
    ev[3:2] = member_event;
    // A full stack holds requests off; a push then would be lost
    pend = r.gie && !stk_full && // RL22
      (tb_req(r.flg, r.en) || grp_req(r.flg, r.en));
    // Phase runs free; only a wake from sleep restarts it
    end_cyc = (r.ph == PH_LAST);
    wake = |(r.flg & ~r.prev); // RL1

    // ==========================================
    // APB slave: answers in the first access cycle
    hit = reg_hit(paddr);
    apb_setup = psel && !penable;
    // Write lands at the access edge, once pready is seen high
    apb_write = psel && penable && r.pready && pwrite;
    n.pready = apb_setup;
    n.pslverr = apb_setup && !hit;
    if (apb_setup) begin
      n.prdata = 32'h0000_0000;
      case (paddr)
        OFS_CTRL: begin
          n.prdata[CTRL_GIE] = r.gie;
          n.prdata[CTRL_EN +: 2] = r.en;
        end
        OFS_FLAG: n.prdata[3:0] = r.flg;
        OFS_STAT: begin
          n.prdata[PC_W-1:0] = r.pc;
          n.prdata[STAT_SLEEP] = r.sleeping;
          n.prdata[STAT_Z] = r.z;
          n.prdata[STAT_C] = r.c;
          n.prdata[STAT_LVL +: STK_LW] = stk_lvl;
          n.prdata[STAT_FULL] = stk_full;
        end
        OFS_DATA: begin
          n.prdata[7:0] = r.tblh;
          n.prdata[DATA_ACC +: 8] = r.acc;
        end
        default: ;
      endcase
    end
    if (apb_write) begin
      if (paddr == OFS_CTRL) begin
        n.gie = pwdata[CTRL_GIE];
        n.en = pwdata[CTRL_EN +: 2];
      end
      if (paddr == OFS_FLAG) begin
        n.flg = r.flg & ~pwdata[3:0]; // RL3
      end
    end

    // ==========================================
    // Cycle sequencer
    n.ph = r.ph + 2'd1; // RL8
    case (r.st)
      ST_EXEC: begin
        if (end_cyc) begin
          if (r.ir_valid) begin
            n.pc = r.pc + 11'd1;
            if (alu.z_we) begin
              n.z = alu.z;
            end
            if (alu.c_we) begin
              n.c = alu.c;
            end
            if (alu.wb && r.ir.to_mem) begin
              n.wr.en = 1'b1;
              n.wr.addr = r.ir.mem_addr;
              n.wr.data = alu.result;
              if (r.ir.mem_addr == PCL_ADDR) begin
                n.pc = {r.pc[PC_W-1:8], alu.result}; // RL10
                extra = 1'b1; // RL10
              end
            end else if (alu.wb) begin
              wr_acc = 1'b1;
            end
            if (alu.skip) begin
              n.pc = r.pc + 11'd2; // RL12
              extra = 1'b1; // RL11
            end
            case (r.ir.op)
              OP_JMP: begin
                n.pc = r.ir.target;
                extra = 1'b1; // RL9
              end
              OP_CALL: begin
                push = 1'b1;
                push_d = r.pc + 11'd1; // RL18
                n.pc = r.ir.target;
                extra = 1'b1; // RL9
              end
              OP_RET: begin
                pop = 1'b1;
                n.pc = stk_top; // RL7
                extra = 1'b1; // RL9
              end
              OP_RETURN_FROM_INTERRUPT: begin
                pop = 1'b1;
                n.pc = stk_top;
                n.gie = 1'b1; // RL6
                extra = 1'b1; // RL9
              end
              OP_TABRD: begin
                n.tab_rd = 1'b1;
                n.tab_addr = {r.pc[PC_W-1:8], r.ir.mem_data};
                extra = 1'b1; // RL9
              end
              OP_HALT: n.st = ST_SLEEP;
              default: ;
            endcase
          end
          if (extra) begin
            n.st = ST_EXTRA;
          end else if (!(r.ir_valid && r.ir.op == OP_HALT)) begin
            bnd = 1'b1;
          end
        end
      end
      ST_EXTRA: begin
        if (end_cyc) begin
          // Program word must be valid by the end of this cycle
          if (r.ir.op == OP_TABRD) begin
            n.wr.en = 1'b1; // RL19
            n.wr.addr = r.ir.mem_addr;
            n.wr.data = tab_data[7:0];
            n.tblh = tab_data[15:8];
          end
          // Second cycle done, interrupts may now be taken
          bnd = 1'b1; // RL23
        end
      end
      ST_INT1: begin
        if (end_cyc) begin
          // Push and vector load share one edge
          push = 1'b1; // RL5
          push_d = r.pc;
          n.pc = r.isrc ? VEC_GRP : VEC_TB;
          n.gie = 1'b0; // RL21
          if (r.isrc) begin
            n.flg[FLG_GRP] = 1'b0; // RL4
          end else begin
            n.flg[FLG_TB] = 1'b0;
          end
          n.st = ST_INT2;
        end
      end
      ST_INT2: begin
        if (end_cyc) begin
          bnd = 1'b1;
        end
      end
      ST_SLEEP: begin
        // Rise only; a flag already high cannot wake
        if (wake) begin // RL1 RL2
          n.st = ST_EXEC;
          n.ir_valid = 1'b0;
          n.ph = 2'd0;
        end
      end
      default: begin
        n.st = ST_EXEC;
        n.ir_valid = 1'b0;
      end
    endcase
    if (wr_acc) begin
      n.acc = alu.result;
    end

    // ==========================================
    // Instruction boundary: interrupt or next fetch
    if (bnd) begin
      if (pend) begin // RL23
        n.st = ST_INT1;
        n.ir_valid = 1'b0;
        n.isrc = !tb_req(r.flg, r.en);
      end else begin
        n.st = ST_EXEC;
        n.ir = instr;
        n.ir_valid = instr_valid;
        n.take = instr_valid;
      end
    end
    n.sleeping = (n.st == ST_SLEEP);

    // Hardware set wins over any clear in the same cycle
    n.flg = n.flg | ev; // RL3
    n.prev = r.flg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.st <= ST_EXEC;
      r.pc <= RST_PC;
    end else begin
      r <= n;
    end
  end
endmodule // cicc_core
`default_nettype wire

// ### cicc_pkg.sv
// Shared constants and types of the interrupt and cycle control block
package cicc_pkg;
  // ==========================================
  // Timing
  localparam int CYC_CLKS = 4;
  localparam logic [1:0] PH_LAST = 2'(CYC_CLKS - 1);
  // ==========================================
  // Widths and stack
  localparam int PC_W = 11;
  localparam int STK_DEPTH = 4;
  localparam int STK_IW = 2;
  localparam int STK_LW = 3;
  // ==========================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  // ==========================================
  // Field positions
  localparam int CTRL_GIE = 0;
  localparam int CTRL_EN = 1;
  localparam int FLG_TB = 0;
  localparam int FLG_GRP = 1;
  localparam int STAT_SLEEP = 11;
  localparam int STAT_Z = 12;
  localparam int STAT_C = 13;
  localparam int STAT_LVL = 14;
  localparam int STAT_FULL = 17;
  localparam int DATA_ACC = 8;
  // ==========================================
  // Reset values, vectors, special addresses
  localparam logic [PC_W-1:0] RST_PC = 11'h000;
  localparam logic [PC_W-1:0] VEC_TB = 11'h004;
  localparam logic [PC_W-1:0] VEC_GRP = 11'h008;
  localparam logic [7:0] PCL_ADDR = 8'h06;
  // ==========================================
  // Types
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
    OP_CPL, OP_INC, OP_DEC, OP_RR, OP_RRC, OP_RL, OP_RLC, OP_MOV,
    OP_SETB, OP_CLRB, OP_SZ, OP_SZB, OP_SNZB, OP_SIZ, OP_SDZ,
    OP_JMP, OP_CALL, OP_RET, OP_RETURN_FROM_INTERRUPT, OP_TABRD, OP_HALT
  } cicc_op_t;
  typedef enum logic [4:0] {
    ST_EXEC = 5'b0_0001,
    ST_EXTRA = 5'b0_0010,
    ST_INT1 = 5'b0_0100,
    ST_INT2 = 5'b0_1000,
    ST_SLEEP = 5'b1_0000
  } cicc_state_t;
  typedef struct packed {
    cicc_op_t op;
    logic to_mem;
    logic use_imm;
    logic [2:0] bit_sel;
    logic [7:0] mem_addr;
    logic [7:0] mem_data;
    logic [7:0] imm;
    logic [PC_W-1:0] target;
  } cicc_instr_t;
  typedef struct packed {
    logic [7:0] result;
    logic z;
    logic c;
    logic z_we;
    logic c_we;
    logic skip;
    logic wb;
  } cicc_alu_t;
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } cicc_wr_t;
  typedef struct packed {
    logic [STK_DEPTH-1:0][PC_W-1:0] mem;
    logic [STK_LW-1:0] lvl;
    logic [PC_W-1:0] top;
  } cicc_stk_t;
  typedef struct packed {
    cicc_state_t st;
    logic [1:0] ph;
    cicc_instr_t ir;
    logic ir_valid;
    logic isrc;
    logic [PC_W-1:0] pc;
    logic [7:0] acc;
    logic z;
    logic c;
    logic gie;
    logic [1:0] en;
    logic [3:0] flg;
    logic [3:0] prev;
    logic [7:0] tblh;
    cicc_wr_t wr;
    logic take;
    logic tab_rd;
    logic [PC_W-1:0] tab_addr;
    logic sleeping;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cicc_regs_t;
endpackage

// ### cicc_alu.sv
// Arithmetic, logic, rotate, bit and skip evaluation
`timescale 1ns/1ps
`default_nettype none
module cicc_alu (
  input wire cicc_pkg::cicc_instr_t ir,
  input wire logic [7:0] acc,
  input wire logic c_in,
  output cicc_pkg::cicc_alu_t res
);
  import cicc_pkg::*;

  function automatic logic [7:0] bit_mask(input logic [2:0] i);
    bit_mask = 8'h01 << i;
  endfunction

  logic [7:0] m;
  logic [7:0] src;
  logic [8:0] s9;

  always_comb begin
    m = ir.mem_data;
    src = ir.use_imm ? ir.imm : ir.mem_data;
    s9 = 9'h000;
    res = '0;
    res.wb = 1'b1;
    res.z_we = 1'b1;
    case (ir.op)
      OP_ADD, OP_ADC: begin
        s9 = {1'b0, acc} + {1'b0, src} + {8'h00, c_in & (ir.op == OP_ADC)};
        res.c_we = 1'b1; // RL15
      end
      OP_SUB, OP_SBC: begin
        s9 = {1'b0, acc} - {1'b0, src} - {8'h00, c_in & (ir.op == OP_SBC)};
        res.c_we = 1'b1; // RL15
      end
      OP_AND: s9 = {1'b0, acc & src};
      OP_OR: s9 = {1'b0, acc | src};
      OP_XOR: s9 = {1'b0, acc ^ src};
      OP_CPL: s9 = {1'b0, ~m};
      OP_INC: s9 = {1'b0, m + 8'h01}; // RL16
      OP_DEC: s9 = {1'b0, m - 8'h01}; // RL16
      default: res.z_we = 1'b0;
    endcase
    res.result = s9[7:0];
    res.c = s9[8];
    res.z = (s9[7:0] == 8'h00); // RL14
    case (ir.op)
      OP_RR: res.result = {m[0], m[7:1]}; // RL17
      OP_RL: res.result = {m[6:0], m[7]}; // RL17
      OP_RRC: begin
        res.result = {c_in, m[7:1]}; // RL17
        res.c = m[0];
        res.c_we = 1'b1;
      end
      OP_RLC: begin
        res.result = {m[6:0], c_in}; // RL17
        res.c = m[7];
        res.c_we = 1'b1;
      end
      OP_MOV: res.result = ir.to_mem ? acc : src;
      OP_SETB: res.result = m | bit_mask(ir.bit_sel); // RL13
      OP_CLRB: res.result = m & ~bit_mask(ir.bit_sel); // RL13
      OP_SZ: begin
        res.result = m;
        res.skip = (m == 8'h00); // RL12
        res.wb = ~ir.to_mem;
      end
      OP_SZB: begin
        res.skip = ~|(m & bit_mask(ir.bit_sel)); // RL12
        res.wb = 1'b0;
      end
      OP_SNZB: begin
        res.skip = |(m & bit_mask(ir.bit_sel)); // RL12
        res.wb = 1'b0;
      end
      OP_SIZ: begin
        res.result = m + 8'h01;
        res.skip = (res.result == 8'h00); // RL12
      end
      OP_SDZ: begin
        res.result = m - 8'h01;
        res.skip = (res.result == 8'h00); // RL12
      end
      OP_NOP, OP_JMP, OP_CALL, OP_RET, OP_RETURN_FROM_INTERRUPT, OP_TABRD, OP_HALT:
        res.wb = 1'b0;
      default: ;
    endcase
  end
endmodule // cicc_alu
`default_nettype wire

// ### cicc_stack.sv
// Return address stack, top word held in a register
`timescale 1ns/1ps
`default_nettype none
module cicc_stack (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [cicc_pkg::PC_W-1:0] push_data,
  output logic [cicc_pkg::PC_W-1:0] top,
  output logic [cicc_pkg::STK_LW-1:0] level,
  output logic full
);
  import cicc_pkg::*;

  cicc_stk_t r;
  cicc_stk_t n;
  logic [STK_LW-1:0] below;

  assign top = r.top;
  assign level = r.lvl;
  assign full = (r.lvl == STK_LW'(STK_DEPTH));

  always_comb begin
    n = r;
    below = r.lvl - 3'd2;
    // Push on a full stack is dropped; old entries stay intact
    if (push && !full) begin
      n.mem[r.lvl[STK_IW-1:0]] = push_data;
      n.top = push_data;
      n.lvl = r.lvl + 3'd1;
    end else if (pop && r.lvl != 3'd0) begin
      n.lvl = r.lvl - 3'd1;
      n.top = (r.lvl > 3'd1) ? r.mem[below[STK_IW-1:0]] : RST_PC;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // cicc_stack
`default_nettype wire

// ### cicc_monitor.sv
// Concurrent checks on the ports of the control block
`timescale 1ns/1ps
`default_nettype none
module cicc_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_take,
  input wire cicc_pkg::cicc_instr_t instr,
  input wire logic [7:0] acc,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic global_interrupt_enable
);
  import cicc_pkg::*;
  // ==========================================
  // Cycle counts and results, timed from take
  // Take is high the cycle after sampling, so $past(instr) is the op
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  take_gap_a: assert property (
    instr_take |=> !instr_take [*3])
    else $error("instruction cycle too short");
  two_cycle_a: assert property (
    instr_take && $past(instr.op) inside {OP_JMP, OP_CALL, OP_RET,
    OP_RETURN_FROM_INTERRUPT, OP_TABRD} |=> !instr_take [*7])
    else $error("branch took one cycle");
  pcl_write_a: assert property (
    instr_take && $past(instr.op) == OP_MOV && $past(instr.to_mem) &&
    $past(instr.mem_addr) == PCL_ADDR |=> !instr_take [*7])
    else $error("pc low write without extra cycle");
  return_from_interrupt_gie_a: assert property (
    instr_take && $past(instr.op) == OP_RETURN_FROM_INTERRUPT
    |-> ##[4:8] global_interrupt_enable)
    else $error("interrupt return left enable low");
  ret_gie_a: assert property (
    instr_take && $past(instr.op) == OP_RET && !global_interrupt_enable
    |-> !global_interrupt_enable [*8])
    else $error("plain return set enable");
  inc_step_a: assert property (
    instr_take && $past(instr.op) == OP_INC && !$past(instr.to_mem)
    |-> ##4 acc == $past(instr.mem_data, 5) + 8'h01)
    else $error("increment not by one");
  zero_flag_a: assert property (
    instr_take && $past(instr.op) == OP_AND
    |-> ##4 zero_flag == (acc == 8'h00))
    else $error("zero flag wrong after logic op");
  add_carry_a: assert property (
    instr_take && $past(instr.op) == OP_ADD && !$past(instr.to_mem) &&
    !$past(instr.use_imm) |-> ##4 {carry_flag, acc} ==
    9'($past(acc)) + 9'($past(instr.mem_data, 5)))
    else $error("add sum or carry wrong");
endmodule // cicc_monitor
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the interrupt and cycle control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cicc_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err, tb_event;
  logic instr_valid, instr_take, zero_flag, carry_flag, gie, tab_rd;
  logic sleeping;
  logic [1:0] member_event;
  logic [7:0] paddr, acc, tblh;
  logic [15:0] tab_data;
  logic [31:0] pwdata, prdata, rd;
  logic [PC_W-1:0] pc, tab_addr, tcap, pc0, pcv;
  cicc_instr_t instr;
  cicc_wr_t mem_wr, wcap;
  int n, miscompares, comparisons;
  cicc_core uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tb_event, .member_event, .instr_valid,
    .instr, .instr_take, .pc, .acc, .zero_flag, .carry_flag,
    .global_interrupt_enable(gie), .mem_wr, .tab_rd, .tab_addr, .tab_data,
    .tblh, .sleeping);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Pulses last one cycle, so keep the last of each
  always @(posedge clk) begin
    if (mem_wr.en) wcap <= mem_wr;
    if (tab_rd) tcap <= tab_addr;
  end
  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic cicc_instr_t mk(cicc_op_t o, logic [7:0] d,
      logic m = 1'b0, logic [7:0] a = 8'h10, logic [2:0] b = 3'h0);
    mk = '{op: o, to_mem: m, use_imm: 1'b0, bit_sel: b, mem_addr: a,
      mem_data: d, imm: d, target: {3'h0, d}};
  endfunction
  // Waits for a take pulse; n counts the clocks since the call
  task automatic wt();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (instr_take !== 1'b1 && n < 80);
    if (n >= 80) chk(32'(n), 32'h0000_0000);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never drives twice at once
    @(posedge clk);
  endtask
  // Sync first: only just after a take is the next sample far enough
  task automatic run(input cicc_instr_t i, input int cyc);
    wt();
    instr <= i;
    wt();
    pc0 = pc;
    instr <= mk(OP_NOP, 8'h00);
    wt();
    chk(32'(n), 32'(cyc));
    @(posedge clk);
  endtask
  task automatic event_in(input logic t, input logic [1:0] m);
    tb_event <= t;
    member_event <= m;
    @(posedge clk);
    tb_event <= 1'b0;
    member_event <= 2'b00;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, tb_event, member_event} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    instr_valid = 1'b1;
    instr = mk(OP_NOP, 8'h00);
    tab_data = 16'hbeef;
    miscompares = 0;
    comparisons = 0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    run(mk(OP_MOV, 8'hf0), 4);
    run(mk(OP_ADD, 8'h20), 4);
    chk({carry_flag, acc}, 9'h110);
    run(mk(OP_SUB, 8'h20), 4);
    chk({carry_flag, acc}, 9'h1f0);
    run(mk(OP_AND, 8'h0f), 4);
    chk({zero_flag, acc}, 9'h100);
    run(mk(OP_DEC, 8'h00), 4);
    chk(acc, 8'hff);
    run(mk(OP_INC, 8'h7f), 4);
    chk(acc, 8'h80);
    run(mk(OP_RL, 8'h81), 4);
    chk(acc, 8'h03);
    run(mk(OP_RRC, 8'h02), 4);
    chk({carry_flag, acc}, 9'h081);
    run(mk(OP_RLC, 8'h80), 4);
    chk({carry_flag, acc}, 9'h100);
    run(mk(OP_ADC, 8'h01), 4);
    chk({carry_flag, acc}, 9'h002);
    run(mk(OP_SETB, 8'h41, 1'b1, 8'h10, 3'h3), 4);
    chk(wcap, {1'b1, 8'h10, 8'h49});
    run(mk(OP_CLRB, 8'hff, 1'b1, 8'h11, 3'h7), 4);
    chk(wcap, {1'b1, 8'h11, 8'h7f});
    run(mk(OP_SZ, 8'h00), 8);
    chk(pc, pc0 + 11'h002);
    run(mk(OP_SNZB, 8'h00, 1'b0, 8'h10, 3'h2), 4);
    chk(pc, pc0 + 11'h001);
    run(mk(OP_SIZ, 8'hff), 8);
    chk(pc, pc0 + 11'h002);
    run(mk(OP_MOV, 8'h00, 1'b1, PCL_ADDR), 8);
    chk(pc, {pc0[10:8], acc});
    run(mk(OP_JMP, 8'h40), 8);
    chk(pc, 11'h040);
    run(mk(OP_CALL, 8'h80), 8);
    pcv = pc0;
    chk(pc, 11'h080);
    run(mk(OP_RET, 8'h00), 8);
    chk(pc, pcv + 11'h001);
    run(mk(OP_TABRD, 8'h33, 1'b1, 8'h20), 8);
    chk(tcap[7:0], 8'h33);
    chk({wcap, tblh}, {1'b1, 8'h20, 8'hef, 8'hbe});
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    wt();
    pcv = pc;
    event_in(1'b1, 2'b00);
    wt();
    chk({gie, pc}, {1'b0, VEC_TB});
    run(mk(OP_RETURN_FROM_INTERRUPT, 8'h00), 8);
    chk(pc, pcv + 11'h001);
    chk(gie, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0000_0005);
    wt();
    pcv = pc;
    event_in(1'b0, 2'b10);
    wt();
    chk(pc, VEC_GRP);
    apb(1'b0, OFS_FLAG, 32'h0000_0000);
    chk(rd[3:0], 4'h8);
    apb(1'b1, OFS_FLAG, 32'h0000_000f);
    run(mk(OP_RET, 8'h00), 8);
    chk({gie, pc}, {1'b0, pcv + 11'h001});
    // Stack filled by calls; the request waits for the first pop
    repeat (4) run(mk(OP_CALL, 8'h80), 8);
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    event_in(1'b1, 2'b00);
    repeat (20) @(posedge clk);
    chk(gie, 1'b1);
    run(mk(OP_RET, 8'h00), 16);
    chk({gie, pc}, {1'b0, VEC_TB});
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    // Flag preset so its later event cannot wake
    event_in(1'b1, 2'b00);
    wt();
    instr <= mk(OP_HALT, 8'h00);
    wt();
    instr <= mk(OP_NOP, 8'h00);
    // Let sleep begin before the event comes
    repeat (4) @(posedge clk);
    event_in(1'b1, 2'b00);
    repeat (12) @(posedge clk);
    chk(sleeping, 1'b1);
    apb(1'b0, OFS_FLAG, 32'h0000_0000);
    chk(rd[3:0], 4'h1);
    event_in(1'b0, 2'b01);
    repeat (3) @(posedge clk);
    chk(sleeping, 1'b0);
    end_of_test();
  end
  // Whole run needs about 500 clocks; allow plenty more
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule // tb_top
bind cicc_core cicc_monitor mon (.clk, .rst, .instr_take, .instr, .acc,
  .zero_flag, .carry_flag, .global_interrupt_enable);
`default_nettype wire
